// ### src/dpc_pkg.sv
// Shared constants and types of the DPLL configuration register group.
// Assumes a byte-wide register map reached through 32-bit AXI4-Lite words.
package dpc_pkg;

  // Register indices; each index sits at byte address 4 * index
  localparam logic [9:0] IDX_BASE     = 10'h300;
  localparam logic [9:0] IDX_LAST     = 10'h31A;
  localparam logic [9:0] IDX_FRW      = 10'h300;
  localparam logic [9:0] IDX_XFER     = 10'h306;
  localparam logic [9:0] IDX_PULL_LO  = 10'h307;
  localparam logic [9:0] IDX_PULL_HI  = 10'h30A;
  localparam logic [9:0] IDX_OL_PHASE = 10'h30D;
  localparam logic [9:0] IDX_FIX_OFF  = 10'h30F;
  localparam logic [9:0] IDX_STEP     = 10'h314;
  localparam logic [9:0] IDX_SLEW     = 10'h316;
  localparam logic [9:0] IDX_HIST     = 10'h318;

  // Bank geometry and bit positions inside the flat byte vector
  localparam int unsigned NBYTES   = 27;
  localparam int unsigned POS_FRW  = 0;
  localparam int unsigned POS_XFER = 48;
  localparam int unsigned POS_PLO  = 56;
  localparam int unsigned POS_PHI  = 80;
  localparam int unsigned POS_OLP  = 104;
  localparam int unsigned POS_FIX  = 120;
  localparam int unsigned POS_STEP = 160;
  localparam int unsigned POS_SLEW = 176;
  localparam int unsigned POS_HIST = 192;
  localparam int unsigned XFER_BIT = 0;

  // Reset values
  localparam logic [47:0] RST_FRW  = 48'h000000000000;
  localparam logic [23:0] RST_PLO  = 24'h000000;
  localparam logic [23:0] RST_PHI  = 24'hFFFFFF;
  localparam logic [15:0] RST_OLP  = 16'h0000;
  localparam logic [39:0] RST_FIX  = 40'h0000000000;
  localparam logic [15:0] RST_STEP = 16'h03E8;
  localparam logic [15:0] RST_SLEW = 16'h0000;
  localparam logic [23:0] RST_HIST = 24'h007530;
  localparam logic [7:0]  RST_XFER = 8'h00;

  localparam logic [8*NBYTES-1:0] RST_BANK = {RST_HIST, RST_SLEW, RST_STEP, RST_FIX,
                                              RST_OLP, RST_PHI, RST_PLO, RST_XFER, RST_FRW};
  // Writable bits per byte; the transfer byte stores nothing
  localparam logic [8*NBYTES-1:0] WMASK_BANK = {{20{8'hFF}}, 8'h00, {6{8'hFF}}};

  // AXI4-Lite
  localparam int unsigned ADDR_W      = 12;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Configuration fields handed to the loop datapath
  typedef struct packed {
    logic [23:0] pull_lo;
    logic [23:0] pull_hi;
    logic [15:0] ol_phase;
    logic [39:0] fix_off;
    logic [15:0] step;
    logic [15:0] slew;
    logic [23:0] hist_timer;
  } dpc_cfg_t;

endpackage : dpc_pkg

// ### src/dpc_byte_bank.sv
// Byte-wide register storage with per-byte reset and write masks.
// Assumes one write port and one read port on the same clock.
`timescale 1ns/10ps
`default_nettype none
module dpc_byte_bank #(
  parameter int unsigned           N     = 27,
  parameter logic [8*N-1:0]        RST   = '0,
  parameter logic [8*N-1:0]        WMASK = '1
) (
  // Clock and reset
  input  wire logic           aclk,
  input  wire logic           aresetn,
  // Write port
  input  wire logic           we,
  input  wire logic [4:0]     waddr,
  input  wire logic [7:0]     wdata,
  // Read port
  input  wire logic           re,
  input  wire logic [4:0]     raddr,
  output var  logic [7:0]     rdata_q,
  // All bytes in parallel
  output var  logic [8*N-1:0] bytes_q
);

  logic [7:0] rdata_d;

  // One flop byte per entry; masked bits stay zero
  for (genvar gi = 0; gi < N; gi++) begin : g_byte
    logic [7:0] d;
    logic [7:0] q;
    always_comb begin
      d = q;
      if (we && (waddr == 5'(gi))) begin
        d = wdata & WMASK[gi*8 +: 8];
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        q <= RST[gi*8 +: 8];
      end else begin
        q <= d;
      end
    end
    assign bytes_q[gi*8 +: 8] = q;
  end

  // Read mux; an index beyond the bank reads zero
  always_comb begin
    rdata_d = rdata_q;
    if (re) begin
      rdata_d = 8'h00;
      if (32'(raddr) < N) begin
        rdata_d = bytes_q[8*raddr +: 8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

endmodule : dpc_byte_bank
`default_nettype wire

// ### src/dpc_dpll_cfg.sv
// DPLL configuration register group with an AXI4-Lite slave port.
// Assumes loop-side inputs come from logic on aclk; software is the only writer.
`timescale 1ns/10ps
`default_nettype none
module dpc_dpll_cfg (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite write address and data
  input  wire logic [dpc_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_awvalid,
  output var  logic                          s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output var  logic                          s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]                    s_axi_bresp,
  output var  logic                          s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read
  input  wire logic [dpc_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  input  wire logic                          s_axi_arvalid,
  output var  logic                          s_axi_arready,
  output var  logic [31:0]                   s_axi_rdata,
  output var  logic [1:0]                    s_axi_rresp,
  output var  logic                          s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Loop state from the DPLL datapath
  input  wire logic                          loop_free_run,
  input  wire logic                          holdover_start,
  input  wire logic                          hist_valid,
  input  wire logic [47:0]                   hist_tw,
  input  wire logic                          fallback_last,
  input  wire logic [47:0]                   last_tw,
  // Settings toward the DPLL datapath
  output var  logic [47:0]                   free_run_tw,
  output var  logic [47:0]                   active_tw_q,
  output var  logic [47:0]                   holdover_tw_q,
  output var  logic                          slew_en_q,
  output var  dpc_pkg::dpc_cfg_t             cfg
);

  // Address decode helpers
  function automatic logic idx_mapped(input logic [dpc_pkg::ADDR_W-1:0] a);
    logic [9:0] idx;
    idx = a[11:2];
    return (a[1:0] == 2'h0) && (idx >= dpc_pkg::IDX_BASE) && (idx <= dpc_pkg::IDX_LAST);
  endfunction : idx_mapped

  function automatic logic [4:0] idx_local(input logic [dpc_pkg::ADDR_W-1:0] a);
    logic [9:0] off;
    off = a[11:2] - dpc_pkg::IDX_BASE;
    return idx_mapped(a) ? off[4:0] : 5'h1F;
  endfunction : idx_local

  // Write channel state
  logic                         awready_q, awready_d;
  logic                         wready_q, wready_d;
  logic                         aw_have_q, aw_have_d;
  logic                         w_have_q, w_have_d;
  logic [dpc_pkg::ADDR_W-1:0]   awaddr_q, awaddr_d;
  logic [7:0]                   wbyte_q, wbyte_d;
  logic                         wlane_q, wlane_d;
  logic                         bvalid_q, bvalid_d;
  logic [1:0]                   bresp_q, bresp_d;
  logic                         aw_take, w_take, do_wr, wr_hit, xfer_hit;

  // Read channel state
  logic                         arready_q, arready_d;
  logic                         rvalid_q, rvalid_d;
  logic [1:0]                   rresp_q, rresp_d;
  logic                         ar_take;
  logic [7:0]                   bank_rdata;
  logic [8*dpc_pkg::NBYTES-1:0] bank_bytes;

  // Tuning word state
  logic [47:0]                  active_tw_d, holdover_tw_d;
  logic                         slew_en_d;

  // Write handshakes: address and data taken in either order
  always_comb begin
    aw_take   = s_axi_awvalid && awready_q;
    w_take    = s_axi_wvalid && wready_q;
    do_wr     = aw_have_q && w_have_q && !bvalid_q;
    wr_hit    = do_wr && idx_mapped(awaddr_q) && wlane_q;
    xfer_hit  = wr_hit && (awaddr_q[11:2] == dpc_pkg::IDX_XFER) && wbyte_q[dpc_pkg::XFER_BIT];
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    awaddr_d  = awaddr_q;
    wbyte_d   = wbyte_q;
    wlane_d   = wlane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (aw_take) begin
      aw_have_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (w_take) begin
      w_have_d = 1'b1;
      wbyte_d  = s_axi_wdata[7:0];     // Upper lanes dropped
      wlane_d  = s_axi_wstrb[0];
    end
    if (do_wr) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = idx_mapped(awaddr_q) ? dpc_pkg::RESP_OKAY : dpc_pkg::RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d  = !w_have_d && !bvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= dpc_pkg::RESP_OKAY;
    end else begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awaddr_q  <= awaddr_d;
      wbyte_q   <= wbyte_d;
      wlane_q   <= wlane_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // Read handshake: one read under way, data from the bank's register
  always_comb begin
    ar_take  = s_axi_arvalid && arready_q;
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    if (ar_take) begin
      rvalid_d = 1'b1;
      rresp_d  = idx_mapped(s_axi_araddr) ? dpc_pkg::RESP_OKAY : dpc_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= dpc_pkg::RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
    end
  end

  // Byte storage; the transfer byte has no writable bits
  dpc_byte_bank #(
    .N     (dpc_pkg::NBYTES),
    .RST   (dpc_pkg::RST_BANK),
    .WMASK (dpc_pkg::WMASK_BANK)
  ) u_bank (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (wr_hit),
    .waddr   (idx_local(awaddr_q)),
    .wdata   (wbyte_q),
    .re      (ar_take),
    .raddr   (idx_local(s_axi_araddr)),
    .rdata_q (bank_rdata),
    .bytes_q (bank_bytes)
  );

  // Bus outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = {24'h000000, bank_rdata};

  // Field views of the bank, least significant byte at the lowest index
  always_comb begin
    free_run_tw    = bank_bytes[dpc_pkg::POS_FRW +: 48];
    cfg.pull_lo    = bank_bytes[dpc_pkg::POS_PLO +: 24];
    cfg.pull_hi    = bank_bytes[dpc_pkg::POS_PHI +: 24];
    cfg.ol_phase   = bank_bytes[dpc_pkg::POS_OLP +: 16];
    cfg.fix_off    = bank_bytes[dpc_pkg::POS_FIX +: 40];
    cfg.step       = bank_bytes[dpc_pkg::POS_STEP +: 16];
    cfg.slew       = bank_bytes[dpc_pkg::POS_SLEW +: 16];
    cfg.hist_timer = bank_bytes[dpc_pkg::POS_HIST +: 24];
  end

  // Tuning word holding register, holdover source and slew enable
  always_comb begin
    active_tw_d   = active_tw_q;
    holdover_tw_d = holdover_tw_q;
    if (xfer_hit || loop_free_run) begin
      active_tw_d = free_run_tw;
    end
    if (holdover_start) begin
      if (hist_valid) begin
        holdover_tw_d = hist_tw;
      end else if (fallback_last) begin
        holdover_tw_d = last_tw;
      end else begin
        holdover_tw_d = free_run_tw;
      end
    end
    slew_en_d = (cfg.slew != 16'h0000);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_tw_q   <= dpc_pkg::RST_FRW;
      holdover_tw_q <= dpc_pkg::RST_FRW;
      slew_en_q     <= 1'b0;
    end else begin
      active_tw_q   <= active_tw_d;
      holdover_tw_q <= holdover_tw_d;
      slew_en_q     <= slew_en_d;
    end
  end

  // Checks on the register group
  a_xfer_copies_word: assert property (@(posedge aclk) disable iff (!aresetn)
    xfer_hit |=> (active_tw_q == $past(free_run_tw)))
    else $error("transfer did not load the holding register");

  a_xfer_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    xfer_hit |=> ##1 (bank_bytes[dpc_pkg::POS_XFER +: 8] == 8'h00))
    else $error("transfer bit held after write");

  a_freerun_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    (loop_free_run && !xfer_hit) |=> (active_tw_q == $past(free_run_tw)))
    else $error("free-run word not applied in free-run mode");

  a_hold_keeps_word: assert property (@(posedge aclk) disable iff (!aresetn)
    (!loop_free_run && !xfer_hit) |=> $stable(active_tw_q))
    else $error("holding register changed without transfer");

  a_reset_tw_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> (free_run_tw == 48'h000000000000) && (active_tw_q == 48'h000000000000))
    else $error("tuning word not zero after reset");

  a_reset_limits: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> (cfg.pull_lo == 24'h000000) && (cfg.pull_hi == 24'hFFFFFF))
    else $error("pull-in limits wrong after reset");

  a_reset_step_hist: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> (cfg.step == 16'h03E8) && (cfg.hist_timer == 24'h007530))
    else $error("step size or history timer wrong after reset");

  a_slew_disable: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg.slew == 16'h0000) |=> !slew_en_q)
    else $error("slew limiting enabled with zero limit");

  a_holdover_source: assert property (@(posedge aclk) disable iff (!aresetn)
    (holdover_start && !hist_valid && !fallback_last) |=> (holdover_tw_q == $past(free_run_tw)))
    else $error("holdover did not take the free-run word");

  a_unused_bits_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> (s_axi_rdata[31:8] == 24'h000000))
    else $error("unused read bits not zero");

  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (aw_have_q && w_have_q && !bvalid_q) |=> s_axi_bvalid)
    else $error("write response missing");

  // Main scenarios
  c_transfer: cover property (@(posedge aclk) disable iff (!aresetn) xfer_hit);
  c_free_run: cover property (@(posedge aclk) disable iff (!aresetn)
    loop_free_run && wr_hit);
  c_holdover: cover property (@(posedge aclk) disable iff (!aresetn)
    holdover_start && !hist_valid);
  c_unmapped: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && (s_axi_rresp == dpc_pkg::RESP_SLVERR));

endmodule : dpc_dpll_cfg
`default_nettype wire

// ### bench/dpc_dpll_cfg_test.sv
// Self-checking bench for the DPLL configuration register group.
// Drives the AXI4-Lite port and the loop-state inputs itself; one 125 MHz clock, no partner model.
`timescale 1ns/10ps
`default_nettype none
module dpc_dpll_cfg_test;
  // Clock, reset, bus and loop-state stimulus
  logic              aclk          = 1'b0;
  logic              aresetn       = 1'b0;
  logic [11:0]       awaddr        = 12'h000;
  logic              awvalid       = 1'b0;
  logic [31:0]       wdata         = 32'h00000000;
  logic [3:0]        wstrb         = 4'h0;
  logic              wvalid        = 1'b0;
  logic              bready        = 1'b0;
  logic [11:0]       araddr        = 12'h000;
  logic              arvalid       = 1'b0;
  logic              rready        = 1'b0;
  logic              loop_free_run = 1'b0;
  logic              holdover_start = 1'b0;
  logic              hist_valid    = 1'b0;
  logic [47:0]       hist_tw       = 48'h000000000000;
  logic              fallback_last = 1'b0;
  logic [47:0]       last_tw       = 48'h000000000000;
  // Design outputs
  logic              awready, wready, bvalid, arready, rvalid, slew_en_q;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata;
  logic [47:0]       free_run_tw, active_tw_q, holdover_tw_q;
  dpc_pkg::dpc_cfg_t cfg;
  // Bookkeeping
  int                errors        = 0;
  int                check_count   = 0;
  logic [215:0]      ev;
  logic [1:0]        resp;
  logic [31:0]       rd;

  dpc_dpll_cfg dpc_dpll_cfg_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .loop_free_run(loop_free_run), .holdover_start(holdover_start), .hist_valid(hist_valid),
    .hist_tw(hist_tw), .fallback_last(fallback_last), .last_tw(last_tw),
    .free_run_tw(free_run_tw), .active_tw_q(active_tw_q), .holdover_tw_q(holdover_tw_q),
    .slew_en_q(slew_en_q), .cfg(cfg)
  );

  // 8 ns clock
  initial begin
    forever #4 aclk = ~aclk;
  end

  // Byte address of a register given its offset from the bank base
  function automatic logic [11:0] ba(int i);
    return 12'((32'h300 + i) * 4);
  endfunction : ba

  // Expected reset byte per register offset
  function automatic logic [7:0] rst_byte(int i);
    case (i)
      10, 11, 12: return 8'hFF;
      20:         return 8'hE8;
      21:         return 8'h03;
      24:         return 8'h30;
      25:         return 8'h75;
      default:    return 8'h00;
    endcase
  endfunction : rst_byte

  // Distinct nonzero write pattern per offset
  function automatic logic [7:0] pat(int i);
    return 8'(i * 37 + 5);
  endfunction : pat

  // Verdict and end of run
  task automatic finish_test;
    $display("Summary: %0d comparisons, %0d mismatches", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // A wait that ran out of its bound
  task automatic give_up(input string what);
    errors++;
    $display("BAD t=%0t timeout waiting for %s", $time, what);
    finish_test();
  endtask : give_up

  // Compare and count
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // AXI4-Lite single write; upper data lanes carry junk that must be ignored
  task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic [3:0] st,
                           output logic [1:0] r);
    int   n;
    logic aw_ok;
    logic w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= {24'hA5A5A5, d};
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && (awready === 1'b1)) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && (wready === 1'b1)) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      n++;
      if (n > 50) give_up("write address or data");
    end
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (n > 50) give_up("write response");
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    // Idle edge so the next call never reassigns a strobe in this time step
    @(posedge aclk);
  endtask : axi_write

  // AXI4-Lite single read
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (n > 50) give_up("read address");
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (n > 50) give_up("read data");
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    // Idle edge so the next call never reassigns a strobe in this time step
    @(posedge aclk);
  endtask : axi_read

  // Main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values at the outputs and through the bus
    check(free_run_tw, 64'h0, "free-run word after reset");
    check({cfg.pull_lo, cfg.pull_hi}, 64'h000000FFFFFF, "pull-in limits after reset");
    check({cfg.ol_phase, cfg.fix_off}, 64'h0, "phase offsets after reset");
    check({cfg.step, cfg.slew, slew_en_q}, {31'h0, 16'h03E8, 16'h0000, 1'b0}, "step and slew");
    check(cfg.hist_timer, 64'h7530, "history timer after reset");
    for (int i = 0; i < 27; i++) begin
      axi_read(ba(i), rd, resp);
      check({resp, rd}, {2'h0, 24'h0, rst_byte(i)}, "reset readback");
    end
    $display("Test reset values done");
    // Fill every byte except the transfer byte, then read back and check field assembly
    ev = '0;
    for (int i = 0; i < 27; i++) begin
      if (i != 6) begin
        ev[8*i +: 8] = pat(i);
        axi_write(ba(i), pat(i), 4'hF, resp); // history bytes get nonzero patterns
        check(resp, 64'h0, "write response okay");
      end
    end
    check(active_tw_q, 64'h0, "holding word untouched without transfer");
    check(free_run_tw, ev[47:0], "free-run word byte order");
    check({cfg.pull_hi, cfg.pull_lo}, ev[103:56], "pull-in limits byte order");
    check(cfg.ol_phase, ev[119:104], "open-loop phase");
    check(cfg.fix_off, ev[159:120], "fixed lock offset");
    check({cfg.slew, cfg.step}, ev[191:160], "step and slew fields");
    check({cfg.hist_timer, slew_en_q}, {ev[215:192], 1'b1}, "timer and slew enable");
    for (int i = 0; i < 27; i++) begin
      axi_read(ba(i), rd, resp);
      check({resp, rd}, {2'h0, 24'h0, ev[8*i +: 8]}, "pattern readback");
    end
    $display("Test field layout done");
    // Transfer strobe copies the word and never reads back
    axi_write(ba(6), 8'hFF, 4'hF, resp);
    check(active_tw_q, ev[47:0], "transfer copies word");
    axi_read(ba(6), rd, resp);
    check({resp, rd}, 64'h0, "transfer bit reads zero");
    $display("Test transfer done");
    // Masked write lane, unmapped and misaligned addresses
    axi_write(ba(0), 8'h5A, 4'h0, resp);
    check(resp, 64'h0, "masked write okay");
    axi_write(ba(27), 8'h5A, 4'hF, resp);
    check(resp, 64'h2, "unmapped write refused");
    axi_read(ba(27), rd, resp);
    check({resp, rd}, {2'h2, 32'h0}, "unmapped read above bank");
    axi_read(ba(-1), rd, resp);
    check({resp, rd}, {2'h2, 32'h0}, "unmapped read below bank");
    axi_read(ba(0) + 12'h001, rd, resp);
    check({resp, rd}, {2'h2, 32'h0}, "misaligned read");
    axi_read(ba(0), rd, resp);
    check({resp, rd}, {2'h0, 24'h0, ev[7:0]}, "masked write stored nothing");
    $display("Test refusals done");
    // Free-run mode applies a new word without the strobe
    loop_free_run <= 1'b1;
    ev[7:0] = 8'hC3;
    axi_write(ba(0), 8'hC3, 4'hF, resp);
    repeat (3) @(posedge aclk);
    check(active_tw_q, ev[47:0], "free-run follows word");
    loop_free_run <= 1'b0;
    $display("Test free-run done");
    // Holdover entry selection for every history and fallback combination
    for (int c = 0; c < 4; c++) begin
      hist_valid <= c[1];
      fallback_last <= c[0];
      hist_tw <= 48'h111122223333;
      last_tw <= 48'h444455556666;
      @(posedge aclk);
      holdover_start <= 1'b1;
      @(posedge aclk);
      holdover_start <= 1'b0;
      @(posedge aclk);
      check(holdover_tw_q, c[1] ? 48'h111122223333 : (c[0] ? 48'h444455556666 : ev[47:0]),
            "holdover word choice");
    end
    $display("Test holdover done");
    // Zero slew limit disables limiting
    axi_write(ba(22), 8'h00, 4'hF, resp);
    axi_write(ba(23), 8'h00, 4'hF, resp);
    repeat (2) @(posedge aclk);
    check({cfg.slew, slew_en_q}, 64'h0, "slew limiting off");
    $display("Test slew disable done");
    // Second reset in mid-run restores defaults
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({free_run_tw, cfg.step}, {48'h0, 16'h03E8}, "word and step after reset");
    check(active_tw_q, 64'h0, "holding word after reset");
    check({cfg.pull_lo, cfg.slew}, 64'h0, "lower limit and slew after reset");
    check({cfg.pull_hi, cfg.hist_timer}, 64'hFFFFFF007530, "limit and timer after reset");
    check({cfg.fix_off, cfg.ol_phase}, 64'h0, "offsets after reset");
    $display("Test second reset done");
    finish_test();
  end
endmodule : dpc_dpll_cfg_test
`default_nettype wire
